// File: hw/pwp_pkg.sv
// constants, register map and field layouts of the pulse-width pair block
// assumes one 50 MHz system clock and an AHB-Lite register port
// Operation
// - interrupt enable gates the overflow request
// - overflow sets flag; only writing 0 clears
// - fault sets status, outputs driven to fault level select; write 0 clears
// - fault polarity picks the active input level
// - polarity field sets each output's active level
// - complementary or own-duty active portions per mode
// - prescale select divides by 1, 8, 32, 128
// - period is 12 bits from low, high bytes
// - high bytes bits 7-4 read zero, ignored
// - only a low-byte write commits a new period
// - committed period applies from the next period
// - duty is 12 bits from low, high bytes
// - duty buffered and committed like the period
// - disable stops counter, outputs off; enable restarts at 1
// - mode bit: 0 complementary, 1 independent
// - independent mode: dead-time value is companion duty
// - fault status cannot clear while input active
package pwp_pkg;

    localparam int unsigned PWP_CNT_W    = 12;
    localparam int unsigned PWP_NSETS    = 3;
    localparam int unsigned PWP_IDX_W    = 3;

    // register word indexes; byte address is four times the index
    localparam logic [2:0] PWP_IDX_ENABLE  = 3'h0;
    localparam logic [2:0] PWP_IDX_CTRL    = 3'h1;
    localparam logic [2:0] PWP_IDX_PER_LO  = 3'h2;
    localparam logic [2:0] PWP_IDX_PER_HI  = 3'h3;
    localparam logic [2:0] PWP_IDX_DUTY_LO = 3'h4;
    localparam logic [2:0] PWP_IDX_DUTY_HI = 3'h5;
    localparam logic [2:0] PWP_IDX_DT_LO   = 3'h6;
    localparam logic [2:0] PWP_IDX_DT_HI   = 3'h7;

    // buffered value sets
    localparam int unsigned PWP_SET_PER  = 0;
    localparam int unsigned PWP_SET_DUTY = 1;
    localparam int unsigned PWP_SET_DT   = 2;

    // pair control bit positions
    localparam int unsigned PWP_CTRL_IRQ_EN = 7;
    localparam int unsigned PWP_CTRL_OVF    = 6;
    localparam int unsigned PWP_CTRL_FAULT  = 5;

    localparam logic [7:0] PWP_RST_BYTE   = 8'h00;
    localparam logic [3:0] PWP_HI_MASK    = 4'hF;
    localparam logic [PWP_CNT_W-1:0] PWP_CNT_START = 12'h001;

    // prescaler terminal counts (divide minus one)
    localparam logic [6:0] PWP_DIV1_M1   = 7'h00;
    localparam logic [6:0] PWP_DIV8_M1   = 7'h07;
    localparam logic [6:0] PWP_DIV32_M1  = 7'h1F;
    localparam logic [6:0] PWP_DIV128_M1 = 7'h7F;

    typedef struct packed {
        logic       reserved;
        logic [1:0] fault_level_sel;
        logic       fault_detect_enable;
        logic       pairing_mode;
        logic       companion_out_enable;
        logic       primary_out_enable;
        logic       module_enable;
    } pwp_enable_t;

    typedef struct packed {
        logic       overflow_irq_enable;
        logic       fault_polarity;
        logic [1:0] output_polarity_sel;
        logic [1:0] prescale_sel;
    } pwp_config_t;

endpackage

// File: hw/pwp_top.sv
// pulse-width pair: control, prescaler, 12-bit period/duty counter, fault latch
// assumes a single AHB-Lite master, whose hready is this slave's hreadyout
//
// Our own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

module pwp_top
    import pwp_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        fault_input,
    output logic             primary_output,
    output logic             primary_output_oe,
    output logic             companion_output,
    output logic             companion_output_oe,
    output logic             overflow_irq
);

    function automatic logic [6:0] div_m1(input logic [1:0] sel);
        unique case (sel)
            2'h0: div_m1 = PWP_DIV1_M1;
            2'h1: div_m1 = PWP_DIV8_M1;
            2'h2: div_m1 = PWP_DIV32_M1;
            2'h3: div_m1 = PWP_DIV128_M1;
        endcase
    endfunction

    // write strobe of one register word in its data phase
    function automatic logic wr_at(input logic                 en,
                                   input logic [PWP_IDX_W-1:0] cur,
                                   input logic [PWP_IDX_W-1:0] idx);
        wr_at = en && (cur == idx);
    endfunction

    // an output is in its active portion until the count passes its value
    function automatic logic in_duty(input logic [PWP_CNT_W-1:0] cnt,
                                     input logic [PWP_CNT_W-1:0] lim);
        in_duty = (cnt <= lim);
    endfunction

    logic                 dp_act_q;
    logic                 dp_wr_q;
    logic                 dp_hit_q;
    logic [PWP_IDX_W-1:0] dp_idx_q;
    logic                 wr_en;
    logic [7:0]           wbyte;

    pwp_enable_t          en_q;
    pwp_config_t          cfg_q;
    logic                 ovf_q;
    logic                 fault_q;

    logic [7:0]           lo_q     [PWP_NSETS];
    logic [3:0]           hi_q     [PWP_NSETS];
    logic [PWP_CNT_W-1:0] commit_q [PWP_NSETS];
    logic [PWP_CNT_W-1:0] active_q [PWP_NSETS];

    logic [6:0]           pre_q;
    logic [PWP_CNT_W-1:0] cnt_q;
    logic                 tick;
    logic                 ovf_evt;
    logic                 fault_act;
    logic                 raw_p;
    logic                 raw_c;
    logic                 lvl_p;
    logic                 lvl_c;
    logic                 run;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign wr_en     = dp_act_q & dp_wr_q & dp_hit_q;
    assign wbyte     = hwdata[7:0];

    // address phase capture
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            dp_act_q <= 1'b0;
            dp_wr_q  <= 1'b0;
            dp_hit_q <= 1'b0;
            dp_idx_q <= '0;
        end
        else if (hready)
        begin
            dp_act_q <= hsel & htrans[1];
            dp_wr_q  <= hwrite;
            dp_hit_q <= (haddr[31:5] == 27'h0000000);
            dp_idx_q <= haddr[4:2];
        end
    end

    // enable register; its top bit always reads 0
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            en_q <= pwp_enable_t'(PWP_RST_BYTE);
        end
        else if (wr_at(wr_en, dp_idx_q, PWP_IDX_ENABLE))
        begin
            en_q          <= pwp_enable_t'(wbyte);
            en_q.reserved <= 1'b0;
        end
    end

    // configuration bits of the pair control register
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            cfg_q <= pwp_config_t'(6'h00);
        end
        else if (wr_at(wr_en, dp_idx_q, PWP_IDX_CTRL))
        begin
            cfg_q <= pwp_config_t'({wbyte[PWP_CTRL_IRQ_EN], wbyte[4:0]});
        end
    end

    assign run = en_q.module_enable;

    // fault input level that counts as active
    assign fault_act = en_q.fault_detect_enable
                     & (fault_input == cfg_q.fault_polarity);

    // overflow flag; hardware set wins over a software clear of 0
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            ovf_q <= 1'b0;
        else if (ovf_evt)
            ovf_q <= 1'b1;
        else if (wr_at(wr_en, dp_idx_q, PWP_IDX_CTRL) && !wbyte[PWP_CTRL_OVF])
            ovf_q <= 1'b0;
    end

    // fault status; held set while the fault input stays active
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            fault_q <= 1'b0;
        else if (fault_act)
            fault_q <= 1'b1;
        else if (wr_at(wr_en, dp_idx_q, PWP_IDX_CTRL) && !wbyte[PWP_CTRL_FAULT])
            fault_q <= 1'b0;
    end

    // buffered period, duty and dead-time byte pairs
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int k = 0; k < PWP_NSETS; k++)
            begin
                lo_q[k]     <= PWP_RST_BYTE;
                hi_q[k]     <= 4'h0;
                commit_q[k] <= '0;
            end
        end
        else if (wr_en)
        begin
            for (int k = 0; k < PWP_NSETS; k++)
            begin
                if (dp_idx_q == PWP_IDX_PER_LO + 3'(2 * k))
                begin
                    lo_q[k]     <= wbyte;
                    commit_q[k] <= {hi_q[k], wbyte};
                end
                if (dp_idx_q == PWP_IDX_PER_HI + 3'(2 * k))
                    hi_q[k] <= wbyte[3:0] & PWP_HI_MASK;
            end
        end
    end

    // prescaler
    assign tick = run & (pre_q >= div_m1(cfg_q.prescale_sel));

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            pre_q <= 7'h00;
        else if (!run || tick)
            pre_q <= 7'h00;
        else
            pre_q <= pre_q + 7'h01;
    end

    // period counter
    assign ovf_evt = tick & (cnt_q >= active_q[PWP_SET_PER]);

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            cnt_q <= PWP_CNT_START;
        else if (!run)
            cnt_q <= PWP_CNT_START;
        else if (ovf_evt)
            cnt_q <= PWP_CNT_START;
        else if (tick)
            cnt_q <= cnt_q + 12'h001;
    end

    // active values load only at a period boundary or while stopped
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int k = 0; k < PWP_NSETS; k++)
                active_q[k] <= '0;
        end
        else if (!run || ovf_evt)
        begin
            for (int k = 0; k < PWP_NSETS; k++)
                active_q[k] <= commit_q[k];
        end
    end

    // waveform
    always_comb
    begin
        raw_p = in_duty(cnt_q, active_q[PWP_SET_DUTY]);
        if (en_q.pairing_mode)
            raw_c = in_duty(cnt_q, active_q[PWP_SET_DT]);
        else
            raw_c = ~raw_p;
        if (fault_q || fault_act)
        begin
            lvl_p = en_q.fault_level_sel[1];
            lvl_c = en_q.fault_level_sel[0];
        end
        else
        begin
            lvl_p = raw_p ^ cfg_q.output_polarity_sel[1];
            lvl_c = raw_c ^ cfg_q.output_polarity_sel[0];
        end
    end

    // primary pin register
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            primary_output    <= 1'b0;
            primary_output_oe <= 1'b0;
        end
        else
        begin
            primary_output    <= run & en_q.primary_out_enable & lvl_p;
            primary_output_oe <= run & en_q.primary_out_enable;
        end
    end

    // companion pin register
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            companion_output    <= 1'b0;
            companion_output_oe <= 1'b0;
        end
        else
        begin
            companion_output    <= run & en_q.companion_out_enable & lvl_c;
            companion_output_oe <= run & en_q.companion_out_enable;
        end
    end

    assign overflow_irq = ovf_q & cfg_q.overflow_irq_enable;

    // read mux over register flops, valid in the data phase
    always_comb
    begin
        hrdata = 32'h00000000;
        if (dp_act_q && !dp_wr_q && dp_hit_q)
        begin
            unique case (dp_idx_q)
                PWP_IDX_ENABLE:  hrdata[7:0] = en_q;
                PWP_IDX_CTRL:    hrdata[7:0] = {cfg_q.overflow_irq_enable, ovf_q,
                                                fault_q, cfg_q.fault_polarity,
                                                cfg_q.output_polarity_sel,
                                                cfg_q.prescale_sel};
                PWP_IDX_PER_LO:  hrdata[7:0] = lo_q[PWP_SET_PER];
                PWP_IDX_PER_HI:  hrdata[3:0] = hi_q[PWP_SET_PER];
                PWP_IDX_DUTY_LO: hrdata[7:0] = lo_q[PWP_SET_DUTY];
                PWP_IDX_DUTY_HI: hrdata[3:0] = hi_q[PWP_SET_DUTY];
                PWP_IDX_DT_LO:   hrdata[7:0] = lo_q[PWP_SET_DT];
                PWP_IDX_DT_HI:   hrdata[3:0] = hi_q[PWP_SET_DT];
            endcase
        end
    end

endmodule

`default_nettype wire

// File: test/pwp_monitor.sv
// checker of port relations of the pulse-width pair top
// assumes a bind from the test top; hready is the slave's own hreadyout
`timescale 1ns/10ps
`default_nettype none
module pwp_monitor
    import pwp_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        nrst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        primary_output,
    input wire logic        primary_output_oe,
    input wire logic        companion_output,
    input wire logic        companion_output_oe,
    input wire logic        overflow_irq
);
    logic       rd_q;
    logic       wr_q;
    logic [7:0] a_q;
    // data phase tracking
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            a_q  <= 8'h00;
        end
        else if (hready)
        begin
            rd_q <= hsel & htrans[1] & ~hwrite;
            wr_q <= hsel & htrans[1] & hwrite;
            a_q  <= haddr[7:0];
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    a_prim_off_noe: assert property (!primary_output_oe |-> !primary_output)
        else $error("primary driven while disabled");
    a_comp_off_noe: assert property (!companion_output_oe |-> !companion_output)
        else $error("companion driven while disabled");
    a_oe_after_wr: assert property ($changed({primary_output_oe, companion_output_oe})
        |-> ($past(wr_q && a_q == 8'h00) || $past(wr_q && a_q == 8'h00, 2)))
        else $error("output enable moved without an enable write");
    a_irq_fall_wr: assert property ($fell(overflow_irq)
        |-> $past(wr_q && a_q == 8'h04))
        else $error("interrupt dropped without a control write");
    a_irq_gate: assert property (rd_q && a_q == 8'h04
        |-> overflow_irq == (hrdata[7] & hrdata[6]))
        else $error("interrupt not flag and enable");
    a_per_hi_zero: assert property (rd_q && a_q == 8'h0C |-> hrdata[7:4] == 4'h0)
        else $error("period high upper bits set");
    a_duty_hi_zero: assert property (rd_q && a_q == 8'h14 |-> hrdata[7:4] == 4'h0)
        else $error("duty high upper bits set");
    a_dt_hi_zero: assert property (rd_q && a_q == 8'h1C |-> hrdata[31:4] == 28'h0000000)
        else $error("dead-time high upper bits set");
    c_irq: cover property ($rose(overflow_irq));
    c_oe: cover property ($rose(primary_output_oe));
    c_fault: cover property (rd_q && a_q == 8'h04 && hrdata[5]);
endmodule
`default_nettype wire

// File: test/pwp_stage.sv
// fault pin source and power stage that counts the cycles each output is high
// assumes the bench clears the counters before each measurement
`timescale 1ns/10ps
`default_nettype none
module pwp_stage
(
    input  wire logic       clk_sys,
    input  wire logic       trip,
    input  wire logic       clr,
    input  wire logic       primary_output,
    input  wire logic       companion_output,
    output logic            fault_input,
    output logic [15:0]     on_p,
    output logic [15:0]     on_c
);
    initial fault_input = 1'b0;
    always @(posedge clk_sys)
    begin
        fault_input <= trip;
        on_p <= clr ? 16'h0000 : on_p + 16'(primary_output);
        on_c <= clr ? 16'h0000 : on_c + 16'(companion_output);
    end
endmodule
`default_nettype wire

// File: test/pwp_top_test.sv
// self-checking bench of the pulse-width pair top
// assumes the stage model on the pins and an AHB-Lite master in this module
`timescale 1ns/10ps
`default_nettype none
module pwp_top_test;
    import pwp_pkg::*;
    logic        clk_sys = 1'b0;
    logic        nrst = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        trip = 1'b0;
    logic        clr = 1'b0;
    logic        rd_ph = 1'b0;
    logic        hreadyout, hresp, fault_input, po, poe, co, coe, irq;
    logic [31:0] hrdata;
    logic [15:0] on_p, on_c;
    int          fail_count = 0;
    int          samples_checked = 0;
    logic [31:0] eq[$];
    string       nq[$];
    always #10 clk_sys = ~clk_sys;
    pwp_top DUT (.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fault_input(fault_input),
        .primary_output(po), .primary_output_oe(poe), .companion_output(co),
        .companion_output_oe(coe), .overflow_irq(irq));
    pwp_stage stage (.clk_sys(clk_sys), .trip(trip), .clr(clr), .primary_output(po),
        .companion_output(co), .fault_input(fault_input), .on_p(on_p), .on_c(on_c));
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            fail_count++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    always @(posedge clk_sys)
        if (rd_ph)
            chk(nq.pop_front(), eq.pop_front(), hrdata);
    // for a read, d is the expected data
    task automatic xfer(logic w, logic [7:0] a, logic [31:0] d, string n = "");
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        rd_ph <= !w;
        eq.push_back(d);
        nq.push_back(n);
        if (w)
            void'(eq.pop_back());
        if (w)
            void'(nq.pop_back());
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd_ph <= 1'b0;
    endtask
    task automatic meas(int n, int ep, int ec);
        @(posedge clk_sys);
        clr <= 1'b1;
        @(posedge clk_sys);
        clr <= 1'b0;
        repeat (n) @(posedge clk_sys);
        #1;
        chk("primary on", 32'(ep), {16'h0, on_p});
        chk("companion on", 32'(ec), {16'h0, on_c});
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        #400000;
        fail_count++;
        summarize();
    end
    initial
    begin
        logic [7:0] r;
        void'($urandom(70));
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        for (int i = 0; i < 8; i++)
            xfer(0, 8'(4 * i), 32'h0, "reset value");
        r = 8'(8'h20 + 4 * $urandom_range(55));
        xfer(1, r, 32'hFF);
        xfer(0, r, 32'h0, "unmapped");
        for (int i = 3; i < 8; i += 2)
        begin
            xfer(1, 8'(4 * i), 32'hFF);
            xfer(0, 8'(4 * i), 32'h0F, "high nibble");
        end
        r = 8'($urandom);
        xfer(1, 8'h08, {24'h0, r});
        xfer(0, 8'h08, {24'h0, r}, "period low");
        chk("response", 32'h0, {31'h0, hresp});
        $display("done registers");
        xfer(1, 8'h0C, 32'h0);
        xfer(1, 8'h08, 32'h6);
        xfer(1, 8'h14, 32'h0);
        xfer(1, 8'h10, 32'h2);
        xfer(1, 8'h1C, 32'h0);
        xfer(1, 8'h18, 32'h4);
        xfer(1, 8'h00, 32'h07);
        for (int s = 0; s < 4; s++)
        begin
            xfer(1, 8'h04, 32'(s << 2));
            repeat (6) @(posedge clk_sys);
            meas(24, s[1] ? 16 : 8, s[0] ? 8 : 16);
        end
        $display("done polarity");
        for (int s = 0; s < 4; s++)
        begin
            xfer(1, 8'h04, 32'(s));
            repeat (6 * (s == 0 ? 1 : 8 << 2 * (s - 1))) @(posedge clk_sys);
            meas(6 * (s == 0 ? 1 : 8 << 2 * (s - 1)), 2 * (s == 0 ? 1 : 8 << 2 * (s - 1)),
                4 * (s == 0 ? 1 : 8 << 2 * (s - 1)));
        end
        $display("done prescaler");
        xfer(1, 8'h04, 32'h0);
        xfer(1, 8'h0C, 32'h1);
        repeat (12) @(posedge clk_sys);
        meas(24, 8, 16);
        xfer(1, 8'h08, 32'h6);
        repeat (270) @(posedge clk_sys);
        meas(262, 2, 260);
        xfer(1, 8'h0C, 32'h0);
        xfer(1, 8'h08, 32'h6);
        xfer(1, 8'h10, 32'h3);
        repeat (270) @(posedge clk_sys);
        meas(24, 12, 12);
        xfer(1, 8'h00, 32'h0F);
        repeat (12) @(posedge clk_sys);
        meas(24, 12, 16);
        $display("done period and duty");
        chk("irq masked", 32'h0, {31'h0, irq});
        xfer(1, 8'h04, 32'h80);
        repeat (8) @(posedge clk_sys);
        chk("irq", 32'h1, {31'h0, irq});
        xfer(0, 8'h04, 32'hC0, "flag set");
        xfer(1, 8'h00, 32'h0);
        repeat (3) @(posedge clk_sys);
        chk("off", 32'h0, {28'h0, po, co, poe, coe});
        xfer(1, 8'h04, 32'h80);
        repeat (20) @(posedge clk_sys);
        chk("irq clear", 32'h0, {31'h0, irq});
        $display("done overflow");
        @(posedge clk_sys) trip <= 1'b1;
        xfer(1, 8'h00, 32'h57);
        repeat (6) @(posedge clk_sys);
        meas(24, 12, 12);
        xfer(0, 8'h04, 32'hC0, "no fault");
        xfer(1, 8'h04, 32'h90);
        repeat (4) @(posedge clk_sys);
        meas(24, 24, 0);
        xfer(1, 8'h04, 32'hD0);
        xfer(0, 8'h04, 32'hF0, "fault held");
        @(posedge clk_sys) trip <= 1'b0;
        repeat (4) @(posedge clk_sys);
        xfer(1, 8'h04, 32'hD0);
        xfer(0, 8'h04, 32'hD0, "fault cleared");
        repeat (6) @(posedge clk_sys);
        meas(24, 12, 12);
        $display("done fault");
        summarize();
    end
endmodule
bind pwp_top pwp_monitor mon (.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .primary_output(primary_output), .primary_output_oe(primary_output_oe),
    .companion_output(companion_output), .companion_output_oe(companion_output_oe),
    .overflow_irq(overflow_irq));
`default_nettype wire
